//--- hdl/clk_sel_pkg.sv
// constants, register map and carrier types of the clock and standby selector
// Overview of operation
// - power mode: 001 STOP, 010 SLEEP, 011 IDLE
// - bit 16 keeps pins active in STOP
// - bit 9 slow oscillator after STOP release
// - bit 8 fast oscillator after STOP release
// - bit 0 selects PLL or direct oscillator
// - bit 1 selects fast or slow system clock
// - status bit shows clock actually in use
// - PLL runs at four times oscillator
// - gear gives undivided, half, quarter, eighth
// - prescaler divides by 2 to 32
// - core clocks follow sysclock, stop in STOP, SLEEP and IDLE
// - tick timer clock is oscillator over 32
// - reset: oscillators run, PLL off, gear one
// - reset: fast, system, core and prescaler clocks equal oscillator; tick timer is oscillator over 32
// - gear codes 000, 100, 101, 110
// - prescale codes 000 through 101
package clk_sel_pkg;
	localparam logic [7:0] standby_control_addr     = 8'h00;
	localparam logic [7:0] pll_use_select_addr      = 8'h04;
	localparam logic [7:0] system_clock_select_addr = 8'h08;
	localparam logic [7:0] osc_control_addr         = 8'h0C;
	localparam logic [7:0] gear_control_addr        = 8'h10;

	localparam logic [2:0] mode_stop  = 3'h1;
	localparam logic [2:0] mode_sleep = 3'h2;
	localparam logic [2:0] mode_idle  = 3'h3;

	localparam int stop_pin_drive_bit      = 16;
	localparam int slow_osc_after_wake_bit = 9;
	localparam int fast_osc_after_wake_bit = 8;
	localparam int multiplier_use_bit      = 0;
	localparam int sysclock_select_bit     = 1;
	localparam int sysclock_status_bit     = 0;
	localparam int fast_osc_en_bit         = 8;
	localparam int slow_osc_en_bit         = 9;
	localparam int pll_on_bit              = 2;
	localparam int sleep_request_bit       = 4;
	localparam int periph_source_bit       = 12;
	localparam int prescale_lsb            = 8;

	localparam logic [2:0] gear_div1 = 3'h0;
	localparam logic [2:0] gear_div2 = 3'h4;
	localparam logic [2:0] gear_div4 = 3'h5;
	localparam logic [2:0] gear_div8 = 3'h6;
	localparam logic [2:0] presc_max = 3'h5;

	localparam logic [2:0] mode_reset     = 3'h3;
	localparam logic [1:0] resp_okay      = 2'h0;
	localparam logic [1:0] resp_slverr    = 2'h2;
	localparam int         pll_mult       = 4;
	localparam int         tick_div       = 32;
	localparam int         switch_stages  = 2;

	typedef enum logic [1:0] {sw_idle, sw_gate_off, sw_settle, sw_gate_on}
		switch_state_t;

	typedef struct packed {
		logic       stop_pin_drive;
		logic       slow_osc_after_wake;
		logic       fast_osc_after_wake;
		logic [2:0] power_mode_select;
	} standby_cfg_t;

	typedef struct packed {
		logic       fast_osc_en;
		logic       slow_osc_en;
		logic       pll_on;
		logic       pin_active;
		logic       core_run;
		logic       low_power;
	} clk_status_t;
endpackage

//--- hdl/clk_div_core.sv
// power-of-two divider producing an enable pulse at the selected clock ratio
`timescale 1ns/1ns
module clk_div_core
	import clk_sel_pkg::*;
#(
	parameter int width = 8
)(
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// source enable and divide ratio as a power of two
	input  wire logic             src_en,
	input  wire logic [2:0]       log2_div,
	// one-cycle enable at the divided rate
	output logic                  div_en
);
	logic [width-1:0] count_reg;
	logic [width-1:0] mask;

	assign mask = width'((1 << log2_div) - 1);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_reg <= '0;
		else if (src_en)
			count_reg <= (count_reg & mask) == mask ? '0 : count_reg + 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			div_en <= 1'b0;
		else
			div_en <= src_en && ((count_reg & mask) == mask);
	end
endmodule

//--- hdl/clock_standby_select.sv
// clock source, gear, prescaler and standby control with lite register port
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module clock_standby_select
	import clk_sel_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write address and data
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	// write response
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	// read channels
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// oscillator ticks, one-cycle enables from the pads
	input  wire logic        osc_tick,
	input  wire logic        slow_osc_clock,
	input  wire logic        low_power_entry,
	input  wire logic        wake_event,
	// clock enable pulses and status
	output logic             high_speed_clock,
	output logic             sysclock_en,
	output logic             cpu_free_clock,
	output logic             prescaler_clock,
	output logic             tick_timer_clock,
	output clk_status_t      status
);
	standby_cfg_t  standby_reg;
	logic          multiplier_use_reg;
	logic          sysclock_sel_reg;
	logic          sysclock_source_status_reg;
	logic [2:0]    osc_reg;
	logic [2:0]    gear_reg;
	logic [2:0]    prescale_select_reg;
	logic          periph_source_select_reg;
	logic          sleep_req_reg;
	logic          low_power_reg;
	logic          src_now_reg;
	switch_state_t sw_state;
	logic [1:0]    settle_reg;
	logic [1:0]    pll_phase_reg;
	logic          aw_hold, w_hold;
	logic [7:0]    aw_addr_reg;
	logic [31:0]   w_data_reg;
	logic [3:0]    w_strb_reg;
	logic          wr_fire;
	logic          fast_en, gear_en, periph_en, presc_en, tick_en;
	logic          sys_raw;

	function automatic logic [2:0] gear_log2(input logic [2:0] code);
		if (code == gear_div2)
			return 3'h1;
		else if (code == gear_div4)
			return 3'h2;
		else if (code == gear_div8)
			return 3'h3;
		else
			return 3'h0;
	endfunction

	function automatic logic byte_wr(input int bitpos);
		return w_strb_reg[bitpos / 8];
	endfunction

	// write channel capture, either order
	assign wr_fire = aw_hold && w_hold && !s_bvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold   <= 1'b0;
			w_hold    <= 1'b0;
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
		end
		else
		begin
			if (s_awvalid && s_awready)
			begin
				aw_hold     <= 1'b1;
				aw_addr_reg <= s_awaddr;
				s_awready   <= 1'b0;
			end
			if (s_wvalid && s_wready)
			begin
				w_hold     <= 1'b1;
				w_data_reg <= s_wdata;
				w_strb_reg <= s_wstrb;
				s_wready   <= 1'b0;
			end
			if (s_bvalid && s_bready)
			begin
				aw_hold   <= 1'b0;
				w_hold    <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_bvalid <= 1'b0;
			s_bresp  <= resp_okay;
		end
		else if (wr_fire)
		begin
			s_bvalid <= 1'b1;
			if (aw_addr_reg == standby_control_addr ||
			    aw_addr_reg == pll_use_select_addr ||
			    aw_addr_reg == system_clock_select_addr ||
			    aw_addr_reg == osc_control_addr ||
			    aw_addr_reg == gear_control_addr)
				s_bresp <= resp_okay;
			else
				s_bresp <= resp_slverr;
		end
		else if (s_bready)
			s_bvalid <= 1'b0;
	end

	// register writes; reserved bits are simply not stored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			standby_reg <= '{1'b0, 1'b0, 1'b1, mode_reset};
			multiplier_use_reg <= 1'b0;
			sysclock_sel_reg   <= 1'b0;
			osc_reg            <= 3'b011;
			gear_reg           <= gear_div1;
			prescale_select_reg      <= 3'h0;
			periph_source_select_reg <= 1'b0;
			sleep_req_reg            <= 1'b0;
		end
		else if (wr_fire)
		begin
			if (aw_addr_reg == standby_control_addr)
			begin
				if (byte_wr(0))
					standby_reg.power_mode_select <= w_data_reg[2:0];
				if (byte_wr(8))
				begin
					standby_reg.slow_osc_after_wake <=
						w_data_reg[slow_osc_after_wake_bit];
					standby_reg.fast_osc_after_wake <=
						w_data_reg[fast_osc_after_wake_bit];
				end
				if (byte_wr(16))
					standby_reg.stop_pin_drive <=
						w_data_reg[stop_pin_drive_bit];
			end
			else if (aw_addr_reg == pll_use_select_addr)
			begin
				if (byte_wr(0))
					multiplier_use_reg <= w_data_reg[multiplier_use_bit];
			end
			else if (aw_addr_reg == system_clock_select_addr)
			begin
				if (byte_wr(0))
					sysclock_sel_reg <= w_data_reg[sysclock_select_bit];
			end
			else if (aw_addr_reg == osc_control_addr)
			begin
				if (byte_wr(8))
					osc_reg[1:0] <= {w_data_reg[fast_osc_en_bit],
					                 w_data_reg[slow_osc_en_bit]};
				if (byte_wr(0))
				begin
					osc_reg[2]    <= w_data_reg[pll_on_bit];
					sleep_req_reg <= w_data_reg[sleep_request_bit];
				end
			end
			else if (aw_addr_reg == gear_control_addr)
			begin
				if (byte_wr(0))
					gear_reg <= w_data_reg[2:0];
				if (byte_wr(8))
				begin
					prescale_select_reg <= w_data_reg[prescale_lsb +: 3];
					periph_source_select_reg <=
						w_data_reg[periph_source_bit];
				end
			end
		end
		else if (wake_event && low_power_reg &&
		         standby_reg.power_mode_select == mode_stop)
		begin
			// leaving stop: oscillators come back as software asked
			osc_reg[1] <= standby_reg.fast_osc_after_wake;
			osc_reg[0] <= standby_reg.slow_osc_after_wake;
		end
	end

	// read channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= resp_okay;
		end
		else if (s_arvalid && s_arready)
		begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b1;
			s_rresp   <= resp_okay;
			s_rdata   <= 32'h0000_0000;
			if (s_araddr == standby_control_addr)
				s_rdata <= {15'h0000, standby_reg.stop_pin_drive, 6'h00,
				            standby_reg.slow_osc_after_wake,
				            standby_reg.fast_osc_after_wake, 5'h00,
				            standby_reg.power_mode_select};
			else if (s_araddr == pll_use_select_addr)
				s_rdata <= {31'h0000_0000, multiplier_use_reg};
			else if (s_araddr == system_clock_select_addr)
				s_rdata <= {30'h0000_0000, sysclock_sel_reg,
				            sysclock_source_status_reg};
			else if (s_araddr == osc_control_addr)
				s_rdata <= {22'h00_0000, osc_reg[0], osc_reg[1], 3'h0,
				            sleep_req_reg, 1'b0, osc_reg[2], 2'h0};
			else if (s_araddr == gear_control_addr)
				s_rdata <= {19'h0_0000, periph_source_select_reg, 1'b0,
				            prescale_select_reg, 5'h00, gear_reg};
			else
				s_rresp <= resp_slverr;
		end
		else if (s_rvalid && s_rready)
		begin
			s_rvalid  <= 1'b0;
			s_arready <= 1'b1;
		end
	end

	// low power entry and wake; oscillators restored per wake bits only on wake from STOP
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			low_power_reg <= 1'b0;
		else if (wake_event)
			low_power_reg <= 1'b0;
		else if (low_power_entry && sleep_req_reg &&
		         (standby_reg.power_mode_select == mode_stop ||
		          standby_reg.power_mode_select == mode_sleep ||
		          standby_reg.power_mode_select == mode_idle))
			low_power_reg <= 1'b1;
	end

	// pll: four output pulses per oscillator tick
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pll_phase_reg <= 2'h0;
		else if (osc_tick)
			pll_phase_reg <= 2'(pll_mult - 1);
		else if (pll_phase_reg != 2'h0)
			pll_phase_reg <= pll_phase_reg - 2'h1;
	end
	assign fast_en = multiplier_use_reg && osc_reg[2] ?
		(osc_tick || pll_phase_reg != 2'h0) : osc_tick;

	// glitch free switch: gate, settle, select, then report
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sw_state   <= sw_idle;
			src_now_reg <= 1'b0;
			settle_reg <= 2'h0;
			sysclock_source_status_reg <= 1'b0;
		end
		else
		begin
			case (sw_state)
			sw_idle:
				if (sysclock_sel_reg != src_now_reg)
					sw_state <= sw_gate_off;
			sw_gate_off:
			begin
				settle_reg <= 2'(switch_stages);
				sw_state   <= sw_settle;
			end
			sw_settle:
				if (settle_reg == 2'h0)
				begin
					src_now_reg <= sysclock_sel_reg;
					sw_state    <= sw_gate_on;
				end
				else
					settle_reg <= settle_reg - 2'h1;
			sw_gate_on:
			begin
				sysclock_source_status_reg <= src_now_reg;
				sw_state <= sw_idle;
			end
			default:
				sw_state <= sw_idle;
			endcase
		end
	end

	clk_div_core #(.width(3)) gear_div (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.src_en   (fast_en),
		.log2_div (gear_log2(gear_reg)),
		.div_en   (gear_en)
	);

	assign periph_en = periph_source_select_reg ? fast_en : gear_en;

	clk_div_core #(.width(5)) presc_div (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.src_en   (periph_en),
		.log2_div (prescale_select_reg > presc_max ?
		           3'h0 : prescale_select_reg),
		.div_en   (presc_en)
	);

	clk_div_core #(.width(5)) tick_div_i (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.src_en   (osc_tick),
		.log2_div (3'($clog2(tick_div))),
		.div_en   (tick_en)
	);

	assign sys_raw = (sw_state == sw_idle || sw_state == sw_gate_on) &&
		(src_now_reg ? slow_osc_clock : gear_en);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			high_speed_clock <= 1'b0;
			sysclock_en      <= 1'b0;
			cpu_free_clock   <= 1'b0;
			prescaler_clock  <= 1'b0;
			tick_timer_clock <= 1'b0;
			status           <= '0;
		end
		else
		begin
			high_speed_clock <= fast_en;
			sysclock_en      <= sys_raw;
			cpu_free_clock   <= sys_raw && !low_power_reg;
			prescaler_clock  <= prescale_select_reg == 3'h0 ?
				periph_en : presc_en;
			tick_timer_clock <= tick_en;
			status <= '{osc_reg[1], osc_reg[0], osc_reg[2],
				!(low_power_reg &&
				  standby_reg.power_mode_select == mode_stop) ||
				standby_reg.stop_pin_drive,
				!low_power_reg, low_power_reg};
		end
	end

	property status_lags_a;
		@(posedge aclk) disable iff (!aresetn)
		$changed(sysclock_source_status_reg) |->
			$past(sw_state) == sw_gate_on;
	endproperty
	switch_status_a: assert property (status_lags_a)
		else $error("status changed outside switch");
	core_gated_a: assert property (@(posedge aclk) disable iff (!aresetn)
		low_power_reg |=> !cpu_free_clock)
		else $error("core clock ran in low power");
	pll_reset_a: assert property (@(posedge aclk)
		$rose(aresetn) |-> !multiplier_use_reg && !sysclock_sel_reg)
		else $error("select not reset");

	// a switch starts, then the system enable stays gated four cycles
	sequence switch_begin_s;
		sw_state == sw_idle && sysclock_sel_reg != src_now_reg;
	endsequence
	sequence output_gated_s;
		(!sysclock_en) [*4];
	endsequence
	property switch_gap_p;
		@(posedge aclk) disable iff (!aresetn)
		switch_begin_s |-> ##2 output_gated_s;
	endproperty
	switch_gap_a: assert property (switch_gap_p)
		else $error("system clock ran during switch");
	property status_idle_p;
		@(posedge aclk) disable iff (!aresetn)
		sw_state == sw_idle |-> sysclock_source_status_reg == src_now_reg;
	endproperty
	status_idle_a: assert property (status_idle_p)
		else $error("status differs from source in use");
	property reserved_zero_p;
		@(posedge aclk) disable iff (!aresetn)
		s_rvalid |-> (s_rdata >> (stop_pin_drive_bit + 1)) == 32'h0000_0000;
	endproperty
	reserved_zero_a: assert property (reserved_zero_p)
		else $error("reserved read bits not zero");
endmodule

//--- dv/testbench.sv
// self-checking bench for the clock and standby selector
`timescale 1ns/1ns
module testbench;
	import clk_sel_pkg::*;
	logic        aclk = 0;
	logic        aresetn = 0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        osc_tick = 0, slow_osc_clock = 0;
	logic        low_power_entry = 0, wake_event = 0;
	logic        hs, sys_en, cpu_clk, presc, tick;
	clk_status_t status;
	logic [7:0]  ph = 8'h00;
	logic        cnt_on = 0;
	int          c_osc, c_hs, c_sys, c_cpu, c_pre;
	int          n_fail = 0;
	int          compares = 0;

	clock_standby_select dut (.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
		.s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
		.s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
		.s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
		.s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
		.s_rvalid(rvalid), .s_rready(rready), .osc_tick(osc_tick),
		.slow_osc_clock(slow_osc_clock), .low_power_entry(low_power_entry),
		.wake_event(wake_event), .high_speed_clock(hs), .sysclock_en(sys_en),
		.cpu_free_clock(cpu_clk), .prescaler_clock(presc),
		.tick_timer_clock(tick), .status(status));

	initial
	begin
		forever #4 aclk = ~aclk;
	end

	// fast oscillator every 4 cycles, slow one every 16
	always @(posedge aclk)
	begin
		ph <= ph + 8'h01;
		osc_tick <= (ph[1:0] == 2'h0);
		slow_osc_clock <= (ph[3:0] == 4'h0);
		if (cnt_on)
		begin
			c_osc += osc_tick;
			c_hs += hs;
			c_sys += sys_en;
			c_cpu += cpu_clk;
			c_pre += presc;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask

	// pulse counts drift by one with the divider phase, so allow a margin
	task automatic near(input int got, input int exp, input int tol);
		compares++;
		if (got < exp - tol || got > exp + tol)
		begin
			$display("unexpected at %0t: count %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask

	task automatic meas(input int cyc);
		c_osc = 0; c_hs = 0; c_sys = 0; c_cpu = 0; c_pre = 0;
		@(posedge aclk) cnt_on <= 1'b1;
		repeat (cyc) @(posedge aclk);
		cnt_on <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		if (n >= 50) n_fail++;
		chk(32'(bresp), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 50);
		d = rdata;
		rready <= 1'b0;
		if (n >= 50) n_fail++;
		chk(32'(rresp), 32'(er));
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d, resp_okay);
		chk(d, exp);
	endtask

	task automatic t_reset;
		rchk(standby_control_addr, 32'h00000103);
		rchk(pll_use_select_addr, 32'h00000000);
		rchk(system_clock_select_addr, 32'h00000000);
		chk(32'({status.fast_osc_en, status.slow_osc_en, status.pll_on}),
			32'h6);
		meas(128);
		near(c_hs, c_osc, 1);
		near(c_sys, c_osc, 1);
		near(c_pre, c_osc, 1);
	endtask

	task automatic t_regs;
		logic [31:0] d;
		wr(standby_control_addr, 32'hFFFDFFF9, resp_okay);
		rchk(standby_control_addr, 32'h00010301);
		wr(standby_control_addr, 32'h00000103, resp_okay);
		wr(pll_use_select_addr, 32'hFFFFFFFE, resp_okay);
		rchk(pll_use_select_addr, 32'h00000000);
		wr(8'h40, 32'hFFFFFFFF, resp_slverr);
		rd(8'h40, d, resp_slverr);
		chk(d, 32'h0);
	endtask

	task automatic swto(input logic [31:0] sel);
		logic [31:0] d;
		int n;
		wr(system_clock_select_addr, sel << 1, resp_okay);
		n = 0;
		do
		begin
			rd(system_clock_select_addr, d, resp_okay);
			n++;
		end while (d[0] !== sel[0] && n < 20);
		chk(d, (sel << 1) | sel);
	endtask

	task automatic t_switch;
		wr(osc_control_addr, 32'h00000300, resp_okay);
		swto(32'h1);
		meas(128);
		near(c_sys, 8, 1);
		near(c_cpu, 8, 1);
		swto(32'h0);
	endtask

	task automatic t_divs;
		logic [2:0] g [4] = '{gear_div1, gear_div2, gear_div4, gear_div8};
		for (int i = 0; i < 4; i++)
		begin
			wr(gear_control_addr, 32'(g[i]), resp_okay);
			meas(128);
			near(c_sys, 32 >> i, 1);
		end
		for (int k = 1; k <= 5; k++)
		begin
			wr(gear_control_addr, 32'(k) << prescale_lsb, resp_okay);
			meas(256);
			near(c_pre, 64 >> k, 1);
		end
		// peripheral source taken from the undivided fast clock, gear at half
		wr(gear_control_addr, 32'h00001104, resp_okay);
		meas(256);
		near(c_pre, 32, 1);
		wr(gear_control_addr, 32'h0, resp_okay);
	endtask

	task automatic t_tick;
		int n;
		n = 0;
		while (tick !== 1'b1 && n < 300)
		begin
			@(posedge aclk);
			n++;
		end
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end while (tick !== 1'b1 && n < 300);
		chk(32'(n), 32'd128);
	endtask

	task automatic t_pll;
		wr(osc_control_addr, 32'h00000304, resp_okay);
		wr(pll_use_select_addr, 32'h1, resp_okay);
		meas(128);
		near(c_hs, 4 * c_osc, 2);
		wr(pll_use_select_addr, 32'h0, resp_okay);
		wr(osc_control_addr, 32'h00000300, resp_okay);
	endtask

	task automatic lp(input logic [31:0] mode, input logic stops);
		wr(standby_control_addr, 32'h00000100 | mode, resp_okay);
		@(posedge aclk) low_power_entry <= 1'b1;
		@(posedge aclk) low_power_entry <= 1'b0;
		meas(64);
		chk(32'(c_cpu == 0), 32'(stops));
		chk(32'(status.low_power), 32'(stops));
		chk(32'({status.pin_active, status.core_run}),
			32'({mode[2:0] != mode_stop || mode[16], !stops}));
		@(posedge aclk) wake_event <= 1'b1;
		@(posedge aclk) wake_event <= 1'b0;
		meas(64);
		near(c_cpu, 16, 1);
		chk(32'({status.fast_osc_en, status.slow_osc_en}),
			32'({1'b1, mode[2:0] != mode_stop}));
	endtask

	task automatic t_lowpower;
		wr(osc_control_addr, 32'h00000310, resp_okay);
		lp(32'h0, 1'b0);
		lp(32'(mode_idle), 1'b1);
		lp(32'(mode_sleep), 1'b1);
		lp(32'(mode_stop), 1'b1);
		lp(32'h00010000 | 32'(mode_stop), 1'b1);
		wr(standby_control_addr, 32'h00000103, resp_okay);
	endtask

	task automatic end_of_test;
		if (n_fail == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// whole run takes about 3600 cycles; the time limit is 50000 cycles
	initial
	begin
		#400000;
		n_fail++;
		end_of_test;
	end

	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_regs;
		t_switch;
		t_divs;
		t_tick;
		t_pll;
		t_lowpower;
		end_of_test;
	end
endmodule
